// *** design/cqg_pkg.sv ***
// package: register map, field layout and constants of the capture/encoder glue
`default_nettype none
package cqg_pkg;
   // register byte addresses
   localparam logic [5:0] CQG_CLK_EN_LOW_OFS  = 6'h00;
   localparam logic [5:0] CQG_CLK_EN_OFS      = 6'h04;
   localparam logic [5:0] CQG_PATH_SEL_LOW    = 6'h08;
   localparam logic [5:0] CQG_PATH_SEL_CE     = 6'h0C;
   localparam logic [5:0] CQG_PATH_SEL_MID    = 6'h10;
   localparam logic [5:0] CQG_PATH_SEL_HIGH   = 6'h14;
   localparam logic [5:0] CQG_TRIP_SEL_OFS    = 6'h18;
   localparam logic [5:0] CQG_IRQ_STATUS_OFS  = 6'h1C;
   localparam logic [5:0] CQG_IRQ_ENABLE_OFS  = 6'h20;
   localparam logic [5:0] CQG_IRQ_CLEAR_OFS   = 6'h24;
   // writable bits and reset values
   localparam logic [31:0] CQG_CLK_EN_MASK    = 32'h01010101;
   localparam logic [31:0] CQG_CLK_EN_RST     = 32'h01010101;
   localparam logic [31:0] CQG_PATH_SEL_MASK  = 32'h07070707;
   localparam logic [31:0] CQG_PATH_SEL_RST   = 32'h01010101;
   localparam logic [31:0] CQG_TRIP_SEL_MASK  = 32'h07777777;
   localparam logic [31:0] CQG_TRIP_SEL_RST   = 32'h00000000;
   localparam logic [31:0] CQG_IRQ_MASK       = 32'h00000003;
   // field geometry
   localparam int CQG_EN_STRIDE   = 8;
   localparam int CQG_SEL_STRIDE  = 8;
   localparam int CQG_TRIP_STRIDE = 4;
   localparam int CQG_NUM_CAP     = 6;
   localparam int CQG_NUM_QEP     = 2;
   localparam int CQG_NUM_PWM     = 7;
   localparam int CQG_NUM_IN      = 14;
   // path select codes
   localparam logic [2:0] CQG_SEL_SYNC = 3'h1;
   localparam logic [2:0] CQG_SEL_FILT = 3'h2;
   // trip-zone four select codes
   localparam logic [2:0] CQG_TRIP_ANY  = 3'h1;
   localparam logic [2:0] CQG_TRIP_ENC1 = 3'h2;
   localparam logic [2:0] CQG_TRIP_ENC2 = 3'h4;
   // filter width in peripheral clocks
   localparam int CQG_FILT_CYC = 6;
   // one encoder's input set
   typedef struct packed {
      logic strobe;
      logic index;
      logic b;
      logic a;
   } cqg_qep_pins_t;
   // bus slave states
   typedef enum logic [1:0] {
      CQG_BUS_IDLE = 2'b01,
      CQG_BUS_RDY  = 2'b10
   } cqg_bus_state_t;
endpackage : cqg_pkg
`default_nettype wire

// *** design/cqg_glue.sv ***
// module: capture and encoder clock gating, input path selection and trip routing
`default_nettype none
module cqg_glue
   import cqg_pkg::*;
#(
   parameter int FILT_CYC = CQG_FILT_CYC
) (
   // clock, reset, clock enable
   input  wire logic                          mclk,
   input  wire logic                          rst_n,
   input  wire logic                          ce,
   // avalon-mm slave
   input  wire logic [5:0]                    avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [31:0]                   avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output logic [31:0]                        avs_readdata,
   output logic                               avs_waitrequest,
   output logic                               irq,
   // system reset and clock gates
   input  wire logic                          system_reset_low,
   output logic [CQG_NUM_CAP-1:0]             capture_clock_gate,
   output logic [CQG_NUM_QEP-1:0]             encoder_clock_gate,
   // capture pins and module side
   input  wire logic [CQG_NUM_CAP-1:0]        cap_pin_i,
   output logic [CQG_NUM_CAP-1:0]             cap_pin_o,
   output logic [CQG_NUM_CAP-1:0]             cap_pin_oe,
   output logic [CQG_NUM_CAP-1:0]             cap_to_module,
   input  wire logic [CQG_NUM_CAP-1:0]        auxiliary_pwm_mode,
   input  wire logic [CQG_NUM_CAP-1:0]        aux_pwm_out,
   // encoder pins and module side
   input  wire cqg_qep_pins_t [CQG_NUM_QEP-1:0] qep_pin_i,
   output cqg_qep_pins_t [CQG_NUM_QEP-1:0]    qep_to_module,
   input  wire logic [CQG_NUM_QEP-1:0]        phase_error_out,
   // pwm trip inputs, active low
   output logic [CQG_NUM_PWM-1:0]             trip_zone_four_low
);

   // elaboration check: the four-bit filter counter serves 1 to 15 clocks only
   if (FILT_CYC < 1 || FILT_CYC > 15) begin : g_filt_range
      $error("cqg_glue: FILT_CYC out of range");
   end

   // control and status storage
   logic [31:0]                clk_en_low, clk_en, sel_low, sel_ce, sel_mid, sel_high, trip_sel;
   logic [CQG_NUM_QEP-1:0]     irq_status, irq_enable, err_q;
   cqg_bus_state_t             bus_state;
   logic [31:0]                wr_word;
   logic                       wr_go;
   logic [CQG_NUM_IN-1:0]      pin_raw, sync1, sync2, filt, path_out;
   logic [3:0]                 filt_cnt [CQG_NUM_IN];
   logic [127:0]               sel_flat;

   // merge written bytes into an old word
   function automatic logic [31:0] cqg_merge(input logic [31:0] old, input logic [31:0] mask);
      logic [31:0] be;
      be = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      cqg_merge = ((old & ~be) | (avs_writedata & be)) & mask;
   endfunction : cqg_merge

   // path choice; unknown codes take the plain synchronised level
   function automatic logic cqg_path(input logic [2:0] code, input logic s, input logic f);
      cqg_path = (code == CQG_SEL_FILT) ? f : s;
   endfunction : cqg_path

   // trip source choice, high means a phase error is flagged
   function automatic logic cqg_trip(input logic [2:0] code, input logic [1:0] e);
      case (code)
         CQG_TRIP_ANY:  cqg_trip = |e;
         CQG_TRIP_ENC1: cqg_trip = e[0];
         CQG_TRIP_ENC2: cqg_trip = e[1];
         default:       cqg_trip = 1'b0;
      endcase
   endfunction : cqg_trip

   // bus handshake: writes finish at once, reads take one wait cycle
   assign wr_go = ce && avs_write;
   assign avs_waitrequest = (avs_read || avs_write) && (!ce || (avs_read && bus_state != CQG_BUS_RDY));
   assign wr_word = avs_writedata;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state <= CQG_BUS_IDLE;
      end else if (ce) begin
         case (bus_state)
            CQG_BUS_IDLE: bus_state <= avs_read ? CQG_BUS_RDY : CQG_BUS_IDLE;
            CQG_BUS_RDY:  bus_state <= CQG_BUS_IDLE;
            default:      bus_state <= CQG_BUS_IDLE;
         endcase
      end
   end

   // read data captured in the wait cycle; unmapped reads give zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h00000000;
      end else if (ce && avs_read && bus_state == CQG_BUS_IDLE) begin
         case (avs_address)
            CQG_CLK_EN_LOW_OFS: avs_readdata <= clk_en_low;
            CQG_CLK_EN_OFS:     avs_readdata <= clk_en;
            CQG_PATH_SEL_LOW:   avs_readdata <= sel_low;
            CQG_PATH_SEL_CE:    avs_readdata <= sel_ce;
            CQG_PATH_SEL_MID:   avs_readdata <= sel_mid;
            CQG_PATH_SEL_HIGH:  avs_readdata <= sel_high;
            CQG_TRIP_SEL_OFS:   avs_readdata <= trip_sel;
            CQG_IRQ_STATUS_OFS: avs_readdata <= {30'h0, irq_status};
            CQG_IRQ_ENABLE_OFS: avs_readdata <= {30'h0, irq_enable};
            default:            avs_readdata <= 32'h00000000;
         endcase
      end
   end

   // control registers; clock enables come up set
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         clk_en_low <= CQG_CLK_EN_RST;
         clk_en     <= CQG_CLK_EN_RST;
         sel_low    <= CQG_PATH_SEL_RST;
         sel_ce     <= CQG_PATH_SEL_RST;
         sel_mid    <= CQG_PATH_SEL_RST;
         sel_high   <= CQG_PATH_SEL_RST;
         trip_sel   <= CQG_TRIP_SEL_RST;
         irq_enable <= 2'h0;
      end else if (wr_go) begin
         case (avs_address)
            CQG_CLK_EN_LOW_OFS: clk_en_low <= cqg_merge(clk_en_low, CQG_CLK_EN_MASK);
            CQG_CLK_EN_OFS:     clk_en     <= cqg_merge(clk_en, CQG_CLK_EN_MASK);
            CQG_PATH_SEL_LOW:   sel_low    <= cqg_merge(sel_low, CQG_PATH_SEL_MASK);
            CQG_PATH_SEL_CE:    sel_ce     <= cqg_merge(sel_ce, CQG_PATH_SEL_MASK);
            CQG_PATH_SEL_MID:   sel_mid    <= cqg_merge(sel_mid, CQG_PATH_SEL_MASK);
            CQG_PATH_SEL_HIGH:  sel_high   <= cqg_merge(sel_high, CQG_PATH_SEL_MASK);
            CQG_TRIP_SEL_OFS:   trip_sel   <= cqg_merge(trip_sel, CQG_TRIP_SEL_MASK);
            CQG_IRQ_ENABLE_OFS: irq_enable <= wr_word[1:0] & CQG_IRQ_MASK[1:0];
            default:            ;
         endcase
      end
   end

   // clock gates: forced on while system reset is low so modules reset cleanly
   always_comb begin
      for (int i = 0; i < CQG_NUM_CAP; i++) begin
         if (i < 4) begin
            capture_clock_gate[i] = !system_reset_low || clk_en_low[i*CQG_EN_STRIDE];
         end else begin
            capture_clock_gate[i] = !system_reset_low || clk_en[(i-4)*CQG_EN_STRIDE];
         end
      end
      for (int j = 0; j < CQG_NUM_QEP; j++) begin
         encoder_clock_gate[j] = !system_reset_low || clk_en[(j+2)*CQG_EN_STRIDE];
      end
   end

   // fourteen input lines in select-field order
   assign pin_raw  = {qep_pin_i[1].strobe, qep_pin_i[1].index, qep_pin_i[1].b, qep_pin_i[1].a,
                      qep_pin_i[0].strobe, qep_pin_i[0].index, qep_pin_i[0].b, qep_pin_i[0].a, cap_pin_i};
   assign sel_flat = {sel_high, sel_mid, sel_ce, sel_low};

   // double synchroniser; first stage only feeds the second
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 14'h0000;
         sync2 <= 14'h0000;
      end else if (ce) begin
         sync1 <= pin_raw;
         sync2 <= sync1;
      end
   end

   // filter: a new level passes only after FILT_CYC steady clocks; shorter glitches are dropped
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         filt <= 14'h0000;
         for (int k = 0; k < CQG_NUM_IN; k++) filt_cnt[k] <= 4'h0;
      end else if (ce) begin
         for (int k = 0; k < CQG_NUM_IN; k++) begin
            if (sync2[k] == filt[k]) begin
               filt_cnt[k] <= 4'h0;
            end else if (filt_cnt[k] == 4'(FILT_CYC - 1)) begin
               filt[k]     <= sync2[k];
               filt_cnt[k] <= 4'h0;
            end else begin
               filt_cnt[k] <= filt_cnt[k] + 4'h1;
            end
         end
      end
   end

   // registered path select toward the modules
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         path_out <= 14'h0000;
      end else if (ce) begin
         for (int k = 0; k < CQG_NUM_IN; k++) begin
            path_out[k] <= cqg_path(sel_flat[k*CQG_SEL_STRIDE +: 3], sync2[k], filt[k]);
         end
      end
   end
   assign cap_to_module = path_out[CQG_NUM_CAP-1:0];
   assign qep_to_module = path_out[CQG_NUM_IN-1:CQG_NUM_CAP];

   // auxiliary pwm: module output onto the pin, registered
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cap_pin_o  <= 6'h00;
         cap_pin_oe <= 6'h00;
      end else if (ce) begin
         cap_pin_o  <= aux_pwm_out & auxiliary_pwm_mode;
         cap_pin_oe <= auxiliary_pwm_mode;
      end
   end

   // trip zone four: selected phase errors, inverted; held inactive high in reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         trip_zone_four_low <= 7'h7F;
      end else if (ce) begin
         for (int p = 0; p < CQG_NUM_PWM; p++) begin
            trip_zone_four_low[p] <= !cqg_trip(trip_sel[p*CQG_TRIP_STRIDE +: 3], phase_error_out);
         end
      end
   end

   // sticky phase-error events; a new rise beats a same-cycle clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         err_q      <= 2'h0;
         irq_status <= 2'h0;
      end else if (ce) begin
         err_q      <= phase_error_out;
         irq_status <= (irq_status & ~((wr_go && avs_address == CQG_IRQ_CLEAR_OFS) ? wr_word[1:0] : 2'h0))
                       | (phase_error_out & ~err_q);
      end
   end
   assign irq = |(irq_status & irq_enable);

   // checks
   default clocking cqg_cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence cqg_filt_sel_s;
      ce && sel_low[2:0] == CQG_SEL_FILT;
   endsequence

   // rising phase error of the second encoder
   sequence cqg_err_rise_s;
      ce && phase_error_out[1] && !err_q[1];
   endsequence

   gate_in_reset_a: assert property (!system_reset_low |-> (&capture_clock_gate) && (&encoder_clock_gate))
      else $error("clock gate off during system reset");
   cap_gate_follow_a: assert property (system_reset_low |-> capture_clock_gate[5] == clk_en[8])
      else $error("capture gate does not follow its bit");
   cap_gate_bit_a: assert property (system_reset_low |-> capture_clock_gate[2] == clk_en_low[16])
      else $error("capture gate three wrong");
   enc_gate_bit_a: assert property (system_reset_low |-> encoder_clock_gate[1] == clk_en[24])
      else $error("encoder gate two wrong");
   enable_reset_one_a: assert property ($rose(rst_n) |->
      clk_en_low == CQG_CLK_EN_RST && clk_en == CQG_CLK_EN_RST)
      else $error("clock enables not one after reset");
   filter_hold_a: assert property (ce && $changed(filt[0]) |->
      $past(sync2[0], 1) == filt[0] && $past(sync2[0], FILT_CYC) == filt[0])
      else $error("filter passed a level held under six clocks");
   cap_filt_path_a: assert property (cqg_filt_sel_s |=> cap_to_module[0] == $past(filt[0]))
      else $error("capture filtered path not routed");
   enc_sync_path_a: assert property (ce && sel_ce[18:16] == CQG_SEL_SYNC |=>
      qep_to_module[0].a == $past(sync2[6]))
      else $error("encoder sync path not routed");
   bad_code_sync_a: assert property (ce && sel_low[2:0] != CQG_SEL_FILT |=>
      cap_to_module[0] == $past(sync2[0]))
      else $error("unknown code not on sync path");
   trip_any_a: assert property (ce && trip_sel[2:0] == CQG_TRIP_ANY |=>
      trip_zone_four_low[0] == !$past(|phase_error_out))
      else $error("trip zone four not inverted error");
   err_sticky_a: assert property (ce && phase_error_out[0] && !err_q[0] |=> irq_status[0])
      else $error("phase error event lost");
   // second encoder, single-source trips, filtered encoder path, first encoder gate and pin side
   err_sticky_two_a: assert property (cqg_err_rise_s |=> irq_status[1])
      else $error("second phase error event lost");
   trip_enc1_a: assert property (ce && trip_sel[6:4] == CQG_TRIP_ENC1 |=>
      trip_zone_four_low[1] == !$past(phase_error_out[0]))
      else $error("trip zone four not inverted first error");
   trip_enc2_a: assert property (ce && trip_sel[10:8] == CQG_TRIP_ENC2 |=>
      trip_zone_four_low[2] == !$past(phase_error_out[1]))
      else $error("trip zone four not inverted second error");
   enc_filt_a: assert property (ce && sel_ce[18:16] == CQG_SEL_FILT |=>
      qep_to_module[0].a == $past(filt[6]))
      else $error("encoder filtered path not routed");
   enc_gate_zero_a: assert property (system_reset_low |-> encoder_clock_gate[0] == clk_en[16])
      else $error("encoder gate one wrong");
   aux_pin_a: assert property (ce |=> cap_pin_oe == $past(auxiliary_pwm_mode))
      else $error("auxiliary pwm enable not on pin");
   ce_hold_a: assert property (!ce |=> $stable(cap_pin_oe) && $stable(cap_pin_o) && $stable(path_out))
      else $error("pin state moved with clock enable low");

endmodule : cqg_glue
`default_nettype wire

// *** test/cqg_far_side.sv ***
// partner model: capture and encoder modules plus their pins
`default_nettype none
module cqg_far_side
   import cqg_pkg::*;
(
   // toward the glue block
   output var logic [CQG_NUM_CAP-1:0]          cap_pin_i,
   output var cqg_qep_pins_t [CQG_NUM_QEP-1:0] qep_pin_i,
   output var logic [CQG_NUM_CAP-1:0]          auxiliary_pwm_mode,
   output var logic [CQG_NUM_CAP-1:0]          aux_pwm_out,
   output var logic [CQG_NUM_QEP-1:0]          phase_error_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // everything idle low until the bench asks
   initial begin
      cap_pin_i = '0;
      qep_pin_i = '0;
      auxiliary_pwm_mode = '0;
      aux_pwm_out = '0;
      phase_error_out = '0;
   end
   // caller holds each level; probe releases it at its hold edge or one edge after arrival
   task automatic put_pin(input bit q, input logic v);
      if (q)
         qep_pin_i[0].a <= v;
      else
         cap_pin_i[0] <= v;
   endtask : put_pin
   // error reported active high by the encoder
   task automatic put_err(input logic [1:0] v);
      phase_error_out <= v;
   endtask : put_err
   // capture module switched to single-channel pwm
   task automatic put_aux(input logic [5:0] m, input logic [5:0] o);
      auxiliary_pwm_mode <= m;
      aux_pwm_out <= o;
   endtask : put_aux
   // all capture and encoder pins at once
   task automatic put_all(input logic [5:0] c, input cqg_qep_pins_t [1:0] e);
      cap_pin_i <= c;
      qep_pin_i <= e;
   endtask : put_all
endmodule : cqg_far_side
`default_nettype wire

// *** test/capture_qep_clock_input_glue_test.sv ***
// bench: self-checking scenarios for the capture/encoder glue
`default_nettype none
module capture_qep_clock_input_glue_test
   import cqg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rst_n, ce, avs_read, avs_write, sys_low, irq, avs_waitrequest;
   logic [5:0] avs_address, cap_en, cap_pin_i, cap_pin_o, cap_pin_oe, cap_mod, aux_mode, aux_out;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic [1:0] enc_en, perr;
   logic [6:0] trip;
   cqg_qep_pins_t [1:0] qep_pin_i, qep_mod;
   int err_count = 0;
   int checked = 0;
   // 20 MHz clock
   always #25 mclk = ~mclk;
   cqg_glue DUT (.mclk(mclk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
      .system_reset_low(sys_low), .capture_clock_gate(cap_en), .encoder_clock_gate(enc_en),
      .cap_pin_i(cap_pin_i), .cap_pin_o(cap_pin_o), .cap_pin_oe(cap_pin_oe), .cap_to_module(cap_mod),
      .auxiliary_pwm_mode(aux_mode), .aux_pwm_out(aux_out), .qep_pin_i(qep_pin_i), .qep_to_module(qep_mod),
      .phase_error_out(perr), .trip_zone_four_low(trip));
   cqg_far_side far (.cap_pin_i(cap_pin_i), .qep_pin_i(qep_pin_i), .auxiliary_pwm_mode(aux_mode),
      .aux_pwm_out(aux_out), .phase_error_out(perr));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // settle n edges, then look at the falling edge
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask : wt
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask : rd
   function automatic logic seen(input bit q);
      return q ? qep_mod[0].a : cap_mod[0];
   endfunction : seen
   // edges from pin rise to module input; 15 means never arrived
   task automatic probe(input bit q, input int hold, input int exp);
      int n;
      @(posedge mclk);
      far.put_pin(q, 1'b1);
      for (n = 1; n <= 14; n++) begin
         @(posedge mclk);
         if (n == hold) far.put_pin(q, 1'b0);
         @(negedge mclk);
         if (seen(q) === 1'b1) break;
      end
      chk(n, exp);
      @(posedge mclk);
      far.put_pin(q, 1'b0);
      repeat (16) @(posedge mclk);
   endtask : probe
   task automatic t_gates;
      rd(CQG_CLK_EN_LOW_OFS, 32'h01010101);
      rd(CQG_CLK_EN_OFS, 32'h01010101);
      rd(CQG_PATH_SEL_LOW, 32'h01010101);
      rd(6'h3C, 32'h0);
      wr(CQG_CLK_EN_LOW_OFS, 32'h01000001);
      wr(CQG_CLK_EN_OFS, 32'h01000001);
      wt(1);
      chk({enc_en, cap_en}, 8'hFF);
      @(posedge mclk);
      sys_low <= 1'b1;
      wt(0);
      chk({enc_en, cap_en}, 8'h99);
      rd(CQG_CLK_EN_LOW_OFS, 32'h01000001);
      @(posedge mclk);
      sys_low <= 1'b0;
      wt(0);
      chk({enc_en, cap_en}, 8'hFF);
      // byte lane zero only: one capture enable cleared, the others kept
      @(posedge mclk);
      avs_byteenable <= 4'h1;
      wr(CQG_CLK_EN_LOW_OFS, 32'h00000000);
      @(posedge mclk);
      avs_byteenable <= 4'hF;
      rd(CQG_CLK_EN_LOW_OFS, 32'h01000000);
   endtask : t_gates
   // every pin through the default sync path, two patterns and back to idle
   task automatic t_wiring;
      @(posedge mclk);
      far.put_all(6'h2A, 8'hC5);
      wt(3);
      chk({qep_mod, cap_mod}, 14'h316A);
      @(posedge mclk);
      far.put_all(6'h15, 8'h3A);
      wt(3);
      chk({qep_mod, cap_mod}, 14'h0E95);
      @(posedge mclk);
      far.put_all(6'h00, 8'h00);
      wt(3);
      chk({qep_mod, cap_mod}, 14'h0000);
   endtask : t_wiring
   task automatic t_paths;
      probe(1'b0, 20, 3);
      wr(CQG_PATH_SEL_LOW, 32'h01010102);
      probe(1'b0, 20, 3 + CQG_FILT_CYC);
      probe(1'b0, 4, 15);
      wr(CQG_PATH_SEL_LOW, 32'h01010107);
      probe(1'b0, 20, 3);
      probe(1'b1, 20, 3);
      wr(CQG_PATH_SEL_CE, 32'h01020101);
      probe(1'b1, 20, 3 + CQG_FILT_CYC);
   endtask : t_paths
   // pwm0 any error, pwm1 encoder one, pwm2 encoder two, rest off
   task automatic t_trip;
      wr(CQG_TRIP_SEL_OFS, 32'h00000421);
      wr(CQG_IRQ_ENABLE_OFS, 32'h1);
      @(posedge mclk);
      far.put_err(2'b01);
      wt(2);
      chk(trip, 7'h7C);
      chk(irq, 1'b1);
      wr(CQG_IRQ_CLEAR_OFS, 32'h1);
      wt(1);
      chk(irq, 1'b0);
      @(posedge mclk);
      far.put_err(2'b10);
      wt(2);
      chk(trip, 7'h7A);
      chk(irq, 1'b0);
      rd(CQG_IRQ_STATUS_OFS, 32'h2);
      wr(CQG_IRQ_ENABLE_OFS, 32'h3);
      wt(1);
      chk(irq, 1'b1);
      wr(CQG_IRQ_CLEAR_OFS, 32'h2);
      wt(1);
      chk(irq, 1'b0);
      rd(CQG_IRQ_CLEAR_OFS, 32'h0);
      @(posedge mclk);
      far.put_err(2'b00);
   endtask : t_trip
   task automatic t_aux;
      @(posedge mclk);
      far.put_aux(6'h04, 6'h04);
      wt(1);
      chk({cap_pin_oe, cap_pin_o}, 12'h104);
      @(posedge mclk);
      far.put_aux(6'h00, 6'h04);
      wt(1);
      chk({cap_pin_oe, cap_pin_o}, 12'h000);
      // clock enable low: pin side must not follow until it returns
      @(posedge mclk);
      ce <= 1'b0;
      far.put_aux(6'h01, 6'h01);
      wt(2);
      chk({cap_pin_oe, cap_pin_o}, 12'h000);
      @(posedge mclk);
      ce <= 1'b1;
      wt(1);
      chk({cap_pin_oe, cap_pin_o}, 12'h041);
   endtask : t_aux
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   // main sequence; clock enable and byte enables start on; t_gates narrows the byte enables and t_aux drops the clock enable for a while
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      sys_low = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = 4'hF;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      t_gates;
      t_wiring;
      t_paths;
      t_trip;
      t_aux;
      end_of_test;
   end
   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      end_of_test;
   end
endmodule : capture_qep_clock_input_glue_test
`default_nettype wire
